// ===== design/trig_ctrl_pkg.sv
// Purpose: shared constants for the global shutter trigger control block
// Assumes: mclk at 200 MHz, all line counts in horizontal line periods
// Notes: register offsets are the byte addresses of the serial control port

package trig_ctrl_pkg;

   // ==========================================================
   // register offsets
   localparam logic [7:0] MASTER_RUN_OFS = 8'h0A;
   localparam logic [7:0] MODE_SEL_OFS = 8'h0B;
   localparam logic [7:0] SYNC_DRIVE_OFS = 8'h36;
   localparam logic [7:0] ABORT_EN_OFS = 8'hAA;
   localparam logic [7:0] FAST_SEL_OFS = 8'hAE;

   // ==========================================================
   // field positions and reset values
   localparam int SYNC_DRIVE_LSB = 4;
   localparam logic MASTER_RUN_RST = 1'h1;
   localparam logic MODE_SEL_RST = 1'h0;
   localparam logic ABORT_EN_RST = 1'h1;
   localparam logic FAST_SEL_RST = 1'h0;
   localparam logic [1:0] SYNC_DRIVE_RST = 2'h0;
   localparam logic [1:0] SYNC_DRIVE_HIZ = 2'h3;

   // ==========================================================
   // line period counts
   localparam logic [15:0] MODE_SWITCH_LINES = 16'h000E;
   localparam logic [15:0] OUTPUT_LATENCY_LINES = 16'h001D;
   localparam logic [15:0] SEQ_HOLDOFF_ALL = 16'h046A;
   localparam logic [15:0] SEQ_HOLDOFF_SUB = 16'h024A;
   localparam logic [15:0] SEQ_ROI_EXTRA = 16'h002A;
   localparam logic [15:0] FAST_HOLDOFF_ALL = 16'h0476;
   localparam logic [15:0] FAST_HOLDOFF_SUB = 16'h0256;
   localparam logic [15:0] FAST_ROI_EXTRA = 16'h0036;

   // ==========================================================
   // exposure offset in real time
   localparam int CLK_MHZ = 200;
   localparam int EXPOSURE_OFFSET_NS = 14260;
   localparam int EXPOSURE_OFFSET_CYC_I = (EXPOSURE_OFFSET_NS * CLK_MHZ + 999) / 1000;
   localparam logic [11:0] EXPOSURE_OFFSET_CYC = 12'(EXPOSURE_OFFSET_CYC_I);

   // ==========================================================
   // readout geometry select and shutter states
   localparam logic [1:0] READ_ALL = 2'h0;
   localparam logic [1:0] READ_SUB = 2'h1;
   localparam logic [1:0] READ_ROI = 2'h2;

   typedef enum logic [1:0] {
      ST_NORMAL = 2'b00,
      ST_SWITCH = 2'b01,
      ST_SEQ = 2'b11,
      ST_FAST = 2'b10
   } shutter_state_e;

endpackage

// ===== design/line_timer.sv
// Purpose: line tick source and master sync pulse generator
// Assumes: ext_line is already synchronised to mclk
// Notes: master_en selects the internal line and frame counters

`timescale 1ns/1ps
`default_nettype none

module line_timer #(
   parameter int LINE_CYCLES = 1100,
   parameter int FRAME_LINES = 1130
) (
   // clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // line source
   input wire logic master_en,
   input wire logic ext_line,
   // timing out
   output logic line_tick,
   output logic hs_drive,
   output logic vs_drive
);

   logic [15:0] cyc_r;
   logic [15:0] line_r;
   logic wrap;

   assign wrap = (cyc_r == 16'(LINE_CYCLES - 1));

   // ==========================================================
   // internal line and frame counters
   always_ff @(posedge mclk) begin
      if (sys_rst || !master_en) begin
         cyc_r <= 16'h0000;
         line_r <= 16'h0000;
      end else if (wrap) begin
         cyc_r <= 16'h0000;
         line_r <= (line_r == 16'(FRAME_LINES - 1)) ? 16'h0000 : line_r + 16'h0001;
      end else begin
         cyc_r <= cyc_r + 16'h0001;
      end
   end

   // ==========================================================
   // tick and sync drive
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         line_tick <= 1'b0;
         hs_drive <= 1'b1;
         vs_drive <= 1'b1;
      end else begin
         line_tick <= master_en ? wrap : ext_line;
         hs_drive <= !(master_en && wrap);
         vs_drive <= !(master_en && wrap && line_r == 16'h0000);
      end
   end

endmodule

`default_nettype wire

// ===== design/shutter_trigger_ctrl.sv
// Purpose: exposure trigger control for a global shutter sensor
// Assumes: pins are asynchronous to mclk; register port is already decoded
// Notes: sync pins are split into value and enable

`timescale 1ns/1ps
`default_nettype none

module shutter_trigger_ctrl #(
   parameter int LINE_CYCLES = 1100,
   parameter int FRAME_LINES = 1130
) (
   // clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // serial control register port
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // readout geometry
   input wire logic [1:0] readout_sel,
   input wire logic [11:0] roi_height_one,
   input wire logic [11:0] roi_height_two,
   // trigger and sync pins
   input wire logic exposure_trigger_n,
   input wire logic vertical_sync_n_i,
   input wire logic horizontal_sync_n_i,
   output logic vertical_sync_n_o,
   output logic vertical_sync_n_oe,
   output logic horizontal_sync_n_o,
   output logic horizontal_sync_n_oe,
   // frame status
   output logic exposure_active,
   output logic readout_active,
   output logic data_start,
   output logic frame_invalid,
   output logic pulse_out_a,
   output logic pulse_out_b
);

   logic master_run_n_r;
   logic trigger_mode_select_r;
   logic retrigger_abort_enable_r;
   logic [1:0] sync_pin_drive_select_r;
   logic immediate_trigger_select_r;
   logic [2:0] trig_sh_r, vs_sh_r, hs_sh_r;
   logic trig_eff_r, trig_eff_nxt;
   logic line_tick, hs_drive, vs_drive;
   trig_ctrl_pkg::shutter_state_e state_r;
   logic [15:0] switch_cnt_r;
   logic [15:0] holdoff_cnt_r, holdoff_lim;
   logic [15:0] latency_cnt_r;
   logic latency_run_r;
   logic [11:0] tail_cnt_r;
   logic exp_tail_r;
   logic is_master, in_trig, in_holdoff, frame_busy;
   logic rise_ev, fall_ev, acc_rise, acc_fall, retrig;
   logic vs_frame, frame_go, wr_mode, abort_sw;

   assign is_master = !master_run_n_r;
   assign in_trig = (state_r == trig_ctrl_pkg::ST_SEQ) || (state_r == trig_ctrl_pkg::ST_FAST);
   assign in_holdoff = holdoff_cnt_r < holdoff_lim;
   assign frame_busy = latency_run_r || readout_active;
   assign wr_mode = reg_wr && (reg_addr == trig_ctrl_pkg::MODE_SEL_OFS);

   // ==========================================================
   // pin synchronisers
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         trig_sh_r <= 3'h7;
         vs_sh_r <= 3'h7;
         hs_sh_r <= 3'h7;
      end else begin
         trig_sh_r <= {trig_sh_r[1:0], exposure_trigger_n};
         vs_sh_r <= {vs_sh_r[1:0], vertical_sync_n_i};
         hs_sh_r <= {hs_sh_r[1:0], horizontal_sync_n_i};
      end
   end

   line_timer #(
      .LINE_CYCLES(LINE_CYCLES),
      .FRAME_LINES(FRAME_LINES)
   ) u_line_timer (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .master_en(is_master),
      .ext_line(hs_sh_r[2] && !hs_sh_r[1]),
      .line_tick(line_tick),
      .hs_drive(hs_drive),
      .vs_drive(vs_drive)
   );

   // ==========================================================
   // control registers
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         master_run_n_r <= trig_ctrl_pkg::MASTER_RUN_RST;
         trigger_mode_select_r <= trig_ctrl_pkg::MODE_SEL_RST;
         retrigger_abort_enable_r <= trig_ctrl_pkg::ABORT_EN_RST;
         sync_pin_drive_select_r <= trig_ctrl_pkg::SYNC_DRIVE_RST;
         immediate_trigger_select_r <= trig_ctrl_pkg::FAST_SEL_RST;
      end else if (reg_wr) begin
         case (reg_addr)
            trig_ctrl_pkg::MASTER_RUN_OFS: master_run_n_r <= reg_wdata[0];
            trig_ctrl_pkg::MODE_SEL_OFS: trigger_mode_select_r <= reg_wdata[0];
            trig_ctrl_pkg::ABORT_EN_OFS: retrigger_abort_enable_r <= reg_wdata[0];
            trig_ctrl_pkg::SYNC_DRIVE_OFS: begin
               sync_pin_drive_select_r <= reg_wdata[trig_ctrl_pkg::SYNC_DRIVE_LSB +: 2];
            end
            trig_ctrl_pkg::FAST_SEL_OFS: immediate_trigger_select_r <= reg_wdata[0];
            default: ;
         endcase
      end
   end

   // ==========================================================
   // register readback
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            trig_ctrl_pkg::MASTER_RUN_OFS: reg_rdata <= {7'h00, master_run_n_r};
            trig_ctrl_pkg::MODE_SEL_OFS: reg_rdata <= {7'h00, trigger_mode_select_r};
            trig_ctrl_pkg::ABORT_EN_OFS: reg_rdata <= {7'h00, retrigger_abort_enable_r};
            trig_ctrl_pkg::SYNC_DRIVE_OFS: reg_rdata <= {2'h0, sync_pin_drive_select_r, 4'h0};
            trig_ctrl_pkg::FAST_SEL_OFS: reg_rdata <= {7'h00, immediate_trigger_select_r};
            default: reg_rdata <= 8'h00;
         endcase
      end
   end

   // ==========================================================
   // holdoff limit per geometry and mode
   always_comb begin
      holdoff_lim = 16'h0000;
      case (readout_sel)
         trig_ctrl_pkg::READ_ALL: begin
            holdoff_lim = (state_r == trig_ctrl_pkg::ST_FAST) ?
               trig_ctrl_pkg::FAST_HOLDOFF_ALL : trig_ctrl_pkg::SEQ_HOLDOFF_ALL;
         end
         trig_ctrl_pkg::READ_SUB: begin
            holdoff_lim = (state_r == trig_ctrl_pkg::ST_FAST) ?
               trig_ctrl_pkg::FAST_HOLDOFF_SUB : trig_ctrl_pkg::SEQ_HOLDOFF_SUB;
         end
         default: begin
            holdoff_lim = 16'(roi_height_one) + 16'(roi_height_two) +
               ((state_r == trig_ctrl_pkg::ST_FAST) ?
               trig_ctrl_pkg::FAST_ROI_EXTRA : trig_ctrl_pkg::SEQ_ROI_EXTRA);
         end
      endcase
   end

   // ==========================================================
   // trigger edge detection
   always_comb begin
      trig_eff_nxt = trig_eff_r;
      if (state_r == trig_ctrl_pkg::ST_FAST) begin
         trig_eff_nxt = trig_sh_r[2];
      end else if (line_tick) begin
         trig_eff_nxt = trig_sh_r[2];
      end
   end

   assign fall_ev = trig_eff_r && !trig_eff_nxt;
   assign rise_ev = !trig_eff_r && trig_eff_nxt;
   // sequential trigger needs slave timing; fast needs master timing
   assign acc_fall = fall_ev && !exposure_active && !(in_holdoff && !retrigger_abort_enable_r) &&
      ((state_r == trig_ctrl_pkg::ST_SEQ && !is_master) ||
      (state_r == trig_ctrl_pkg::ST_FAST && is_master));
   assign acc_rise = rise_ev && exposure_active && !exp_tail_r &&
      !(in_holdoff && !retrigger_abort_enable_r);
   assign retrig = acc_rise && in_holdoff && frame_busy;
   assign vs_frame = (state_r == trig_ctrl_pkg::ST_NORMAL) && !is_master &&
      vs_sh_r[2] && !vs_sh_r[1];
   assign frame_go = acc_rise || vs_frame ||
      (state_r == trig_ctrl_pkg::ST_NORMAL && is_master && line_tick && !vs_drive);
   assign abort_sw = wr_mode && frame_busy &&
      (reg_wdata[0] || (in_trig && in_holdoff));

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         trig_eff_r <= 1'b1;
      end else begin
         trig_eff_r <= trig_eff_nxt;
      end
   end

   // ==========================================================
   // mode switching
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         state_r <= trig_ctrl_pkg::ST_NORMAL;
         switch_cnt_r <= 16'h0000;
      end else if (wr_mode && state_r != trig_ctrl_pkg::ST_SWITCH) begin
         state_r <= trig_ctrl_pkg::ST_SWITCH;
         switch_cnt_r <= 16'h0000;
      end else if (state_r == trig_ctrl_pkg::ST_SWITCH && line_tick) begin
         if (switch_cnt_r == trig_ctrl_pkg::MODE_SWITCH_LINES - 16'h0001) begin
            if (!trigger_mode_select_r) begin
               state_r <= trig_ctrl_pkg::ST_NORMAL;
            end else if (immediate_trigger_select_r && is_master) begin
               state_r <= trig_ctrl_pkg::ST_FAST;
            end else begin
               state_r <= trig_ctrl_pkg::ST_SEQ;
            end
         end
         switch_cnt_r <= switch_cnt_r + 16'h0001;
      end
   end

   // ==========================================================
   // exposure window
   always_ff @(posedge mclk) begin
      if (sys_rst || !in_trig) begin
         exposure_active <= 1'b0;
         exp_tail_r <= 1'b0;
         tail_cnt_r <= 12'h000;
      end else if (acc_fall) begin
         exposure_active <= 1'b1;
         exp_tail_r <= 1'b0;
      end else if (acc_rise) begin
         exp_tail_r <= 1'b1;
         tail_cnt_r <= trig_ctrl_pkg::EXPOSURE_OFFSET_CYC - 12'h001;
      end else if (exp_tail_r) begin
         if (tail_cnt_r == 12'h000) begin
            exposure_active <= 1'b0;
            exp_tail_r <= 1'b0;
         end else begin
            tail_cnt_r <= tail_cnt_r - 12'h001;
         end
      end
   end

   // ==========================================================
   // holdoff, latency and readout
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         holdoff_cnt_r <= 16'hFFFF;
         latency_cnt_r <= 16'h0000;
         latency_run_r <= 1'b0;
         readout_active <= 1'b0;
         data_start <= 1'b0;
         frame_invalid <= 1'b0;
      end else begin
         data_start <= 1'b0;
         frame_invalid <= retrig || abort_sw;
         if (abort_sw) begin
            latency_run_r <= 1'b0;
            readout_active <= 1'b0;
         end else if (frame_go) begin
            holdoff_cnt_r <= 16'h0000;
            latency_cnt_r <= 16'h0000;
            latency_run_r <= 1'b1;
            readout_active <= 1'b0;
         end else if (line_tick) begin
            if (holdoff_cnt_r != 16'hFFFF) begin
               holdoff_cnt_r <= holdoff_cnt_r + 16'h0001;
            end
            if (latency_run_r) begin
               if (latency_cnt_r == trig_ctrl_pkg::OUTPUT_LATENCY_LINES - 16'h0001) begin
                  latency_run_r <= 1'b0;
                  readout_active <= 1'b1;
                  data_start <= 1'b1;
               end
               latency_cnt_r <= latency_cnt_r + 16'h0001;
            end else if (readout_active && !in_holdoff) begin
               readout_active <= 1'b0;
            end
         end
      end
   end

   // ==========================================================
   // sync pins and pulse outputs
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         horizontal_sync_n_o <= 1'b1;
         vertical_sync_n_o <= 1'b1;
         horizontal_sync_n_oe <= 1'b0;
         vertical_sync_n_oe <= 1'b0;
         pulse_out_a <= 1'b0;
         pulse_out_b <= 1'b0;
      end else begin
         horizontal_sync_n_o <= hs_drive;
         vertical_sync_n_o <= vs_drive;
         horizontal_sync_n_oe <= is_master &&
            sync_pin_drive_select_r != trig_ctrl_pkg::SYNC_DRIVE_HIZ;
         vertical_sync_n_oe <= is_master &&
            sync_pin_drive_select_r != trig_ctrl_pkg::SYNC_DRIVE_HIZ;
         pulse_out_a <= exposure_active && state_r != trig_ctrl_pkg::ST_FAST;
         pulse_out_b <= readout_active && state_r != trig_ctrl_pkg::ST_FAST;
      end
   end

   // ==========================================================
   // checks
   chk_reset_vals: assert property (@(posedge mclk) $past(sys_rst) |->
      master_run_n_r && retrigger_abort_enable_r && !trigger_mode_select_r &&
      !immediate_trigger_select_r)
      else $error("control bits not at reset values");

   chk_switch_entry: assert property (@(posedge mclk) disable iff (sys_rst)
      (wr_mode && state_r != trig_ctrl_pkg::ST_SWITCH) |=> state_r == trig_ctrl_pkg::ST_SWITCH)
      else $error("mode write did not start switch");

   chk_switch_lines: assert property (@(posedge mclk) disable iff (sys_rst)
      (state_r == trig_ctrl_pkg::ST_SWITCH && $past(state_r) != trig_ctrl_pkg::ST_SWITCH)
      |-> switch_cnt_r == 16'h0000)
      else $error("switch line count not cleared");

   chk_switch_exit: assert property (@(posedge mclk) disable iff (sys_rst)
      ($past(state_r) == trig_ctrl_pkg::ST_SWITCH && state_r != trig_ctrl_pkg::ST_SWITCH &&
      !$past(wr_mode)) |->
      $past(switch_cnt_r) == trig_ctrl_pkg::MODE_SWITCH_LINES - 16'h0001)
      else $error("mode entered before 14 lines");

   chk_retrig_invalid: assert property (@(posedge mclk) disable iff (sys_rst)
      retrig |=> frame_invalid)
      else $error("retrigger did not invalidate frame");

   chk_holdoff_ignore: assert property (@(posedge mclk) disable iff (sys_rst)
      (in_trig && in_holdoff && !retrigger_abort_enable_r && rise_ev)
      |=> holdoff_cnt_r != 16'h0000 || $past(holdoff_cnt_r) == 16'h0000)
      else $error("edge inside holdoff was taken");

   chk_holdoff_fall: assert property (@(posedge mclk) disable iff (sys_rst)
      (in_trig && in_holdoff && !retrigger_abort_enable_r && fall_ev && !exposure_active)
      |=> !exposure_active)
      else $error("fall inside holdoff started exposure");

   chk_seq_no_vs: assert property (@(posedge mclk) disable iff (sys_rst)
      (state_r == trig_ctrl_pkg::ST_SEQ && vs_sh_r[2] && !vs_sh_r[1] && !acc_rise)
      |=> !latency_run_r || $past(latency_run_r))
      else $error("vertical sync used in sequential mode");

   chk_fast_pulses: assert property (@(posedge mclk) disable iff (sys_rst)
      ($past(state_r) == trig_ctrl_pkg::ST_FAST) |-> !pulse_out_a && !pulse_out_b)
      else $error("pulse output active in fast mode");

   chk_hiz_pins: assert property (@(posedge mclk) disable iff (sys_rst)
      $past(sync_pin_drive_select_r) == trig_ctrl_pkg::SYNC_DRIVE_HIZ |->
      !horizontal_sync_n_oe && !vertical_sync_n_oe)
      else $error("sync pins driven while floating selected");

   chk_fast_master: assert property (@(posedge mclk) disable iff (sys_rst)
      acc_fall && state_r == trig_ctrl_pkg::ST_FAST |-> is_master ##1 exposure_active)
      else $error("fast exposure did not start on fall");

   chk_exp_offset: assert property (@(posedge mclk) disable iff (sys_rst)
      (acc_rise && in_trig) |=> exposure_active [*8])
      else $error("exposure ended before offset");

   chk_latency: assert property (@(posedge mclk) disable iff (sys_rst)
      data_start |->
      $past(latency_cnt_r) == trig_ctrl_pkg::OUTPUT_LATENCY_LINES - 16'h0001)
      else $error("data output latency wrong");

endmodule

`default_nettype wire

// ===== dv/cam_ctl_model.sv
// Purpose: camera controller model driving trigger and sync pins
// Assumes: slave line period of HS_PERIOD mclk cycles
// Notes: hs stands high while hs_run is low

`timescale 1ns/1ps
`default_nettype none

module cam_ctl_model #(
   parameter int HS_PERIOD = 8
) (
   // clock and line enable
   input wire logic mclk,
   input wire logic hs_run,
   // pins toward the sensor
   output logic exposure_trigger_n,
   output logic vertical_sync_n,
   output logic horizontal_sync_n
);
   // ==========================================================
   // idle levels and line pulses
   int cnt = 0;

   initial begin
      exposure_trigger_n = 1'b1;
      vertical_sync_n = 1'b1;
      horizontal_sync_n = 1'b1;
   end

   always @(negedge mclk) begin
      cnt <= (cnt == HS_PERIOD - 1) ? 0 : cnt + 1;
      horizontal_sync_n <= !(hs_run && cnt == 0);
   end

   // ==========================================================
   // low trigger pulse of cyc cycles, then back to idle high
   task automatic trig(input int cyc);
      @(negedge mclk);
      exposure_trigger_n = 1'b0;
      repeat (cyc) @(negedge mclk);
      exposure_trigger_n = 1'b1;
   endtask

   // one-cycle low pulse on vertical sync
   task automatic vsync();
      @(negedge mclk);
      vertical_sync_n = 1'b0;
      @(negedge mclk);
      vertical_sync_n = 1'b1;
   endtask
endmodule

`default_nettype wire

// ===== dv/shutter_trigger_ctrl_tb.sv
// Purpose: self-checking bench for the shutter trigger control block
// Assumes: line period of 8 mclk cycles, slave and master alike
// Notes: sync pins resolved from the block's enables

`timescale 1ns/1ps
`default_nettype none

module shutter_trigger_ctrl_tb;
   // ==========================================================
   // clock, pins and counters
   logic mclk, sys_rst, reg_wr, reg_rd, hs_run;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic trig_n, vs_n, ctl_hs, hs_o, hs_oe, vs_o, vs_oe, exp_act, ds, inv, pa, ro, pb;
   wire logic hs_pin = hs_oe ? hs_o : ctl_hs;
   wire logic vs_pin = vs_oe ? vs_o : vs_n;
   int n_mismatch = 0, total_checks = 0, n_inv = 0, n_pa = 0, n_exp, n_ds, n_lat, pa0;
   int n_dsa = 0, n_hs = 0, n_vs = 0;
   localparam int OFS = 2852;

   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   always @(posedge mclk) if (inv === 1'b1) n_inv <= n_inv + 1;
   always @(posedge mclk) if (pa === 1'b1) n_pa <= n_pa + 1;
   always @(posedge mclk) if (ds === 1'b1) n_dsa <= n_dsa + 1;
   always @(posedge mclk) if (hs_o === 1'b0) n_hs <= n_hs + 1;
   always @(posedge mclk) if (vs_o === 1'b0) n_vs <= n_vs + 1;

   shutter_trigger_ctrl #(.LINE_CYCLES(8)) u_dut (
      .mclk(mclk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .readout_sel(2'h0), .roi_height_one(12'h000), .roi_height_two(12'h000),
      .exposure_trigger_n(trig_n), .vertical_sync_n_i(vs_pin),
      .horizontal_sync_n_i(hs_pin), .vertical_sync_n_o(vs_o), .vertical_sync_n_oe(vs_oe),
      .horizontal_sync_n_o(hs_o), .horizontal_sync_n_oe(hs_oe), .exposure_active(exp_act),
      .readout_active(ro), .data_start(ds), .frame_invalid(inv), .pulse_out_a(pa),
      .pulse_out_b(pb));
   cam_ctl_model u_ctl (.mclk(mclk), .hs_run(hs_run), .exposure_trigger_n(trig_n),
      .vertical_sync_n(vs_n), .horizontal_sync_n(ctl_hs));

   // ==========================================================
   // access and compare tasks
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic near(input string what, input int v, input int e, input int tol);
      check(what, 16'(v >= e - tol && v <= e + tol), 16'h0001);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge mclk);
      reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
      @(negedge mclk);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge mclk);
      reg_rd = 1'b0;
      check(what, {8'h00, reg_rdata}, {8'h00, exp});
   endtask
   task automatic lines(input int n);
      repeat (n * 8) @(negedge mclk);
   endtask
   // one trigger pulse; measures start delay, exposure length, data start
   task automatic frame(input int cyc, input bit align);
      n_exp = 0;
      n_ds = 0;
      n_lat = 0;
      if (align) @(negedge hs_pin);
      fork
         u_ctl.trig(cyc);
      join_none
      while (exp_act !== 1'b1 && n_lat < 60) begin
         @(negedge mclk);
         n_lat++;
      end
      while (exp_act === 1'b1 && n_exp < 5000) begin
         @(negedge mclk);
         n_exp++;
         if (ds === 1'b1 && n_ds == 0) n_ds = n_exp;
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // ==========================================================
   // tests
   initial begin
      sys_rst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      hs_run = 1'b0;
      repeat (3) @(negedge mclk);
      sys_rst = 1'b0;
      rd(trig_ctrl_pkg::MASTER_RUN_OFS, 8'h01, "master_run");
      rd(trig_ctrl_pkg::MODE_SEL_OFS, 8'h00, "mode_sel");
      rd(trig_ctrl_pkg::ABORT_EN_OFS, 8'h01, "abort_en");
      rd(trig_ctrl_pkg::SYNC_DRIVE_OFS, 8'h00, "sync_drive");
      rd(trig_ctrl_pkg::FAST_SEL_OFS, 8'h00, "fast_sel");
      rd(8'h55, 8'h00, "unmapped");
      check("hs_oe_stopped", {15'h0000, hs_oe}, 16'h0000);
      $display("test reset values done");
      // sequential trigger as timing slave; mode write 31 lines after vertical sync
      hs_run = 1'b1;
      lines(4);
      u_ctl.vsync();
      lines(31);
      check("normal_vs_frame", 16'(n_dsa), 16'h0001);
      wr(trig_ctrl_pkg::MODE_SEL_OFS, 8'h01);
      lines(16);
      check("mode_write_invalid", 16'(n_inv), 16'h0001);
      rd(trig_ctrl_pkg::MODE_SEL_OFS, 8'h01, "mode_sel");
      u_ctl.vsync();
      lines(31);
      check("seq_vs_ignored", 16'(n_dsa), 16'h0001);
      frame(24, 1'b1);
      near("seq_exp", n_exp, 24 + OFS, 4);
      near("seq_latency", n_ds, 24 + 29 * 8, 10);
      check("seq_pulse_a", 16'(n_pa != 0), 16'h0001);
      check("seq_readout", {15'h0000, ro}, 16'h0001);
      check("seq_pulse_b", {15'h0000, pb}, 16'h0001);
      lines(20);
      frame(24, 1'b1);
      check("retrig_invalid", 16'(n_inv), 16'h0002);
      wr(trig_ctrl_pkg::ABORT_EN_OFS, 8'h00);
      lines(20);
      frame(24, 1'b1);
      check("held_off_exp", 16'(n_exp), 16'h0000);
      lines(10);
      wr(trig_ctrl_pkg::MODE_SEL_OFS, 8'h00);
      lines(2);
      check("early_exit_invalid", 16'(n_inv), 16'h0003);
      check("early_exit_readout", {15'h0000, ro}, 16'h0000);
      $display("test sequential trigger done");
      // fast trigger as timing master, chosen in standby
      lines(16);
      wr(trig_ctrl_pkg::FAST_SEL_OFS, 8'h01);
      wr(trig_ctrl_pkg::ABORT_EN_OFS, 8'h01);
      hs_run = 1'b0;
      wr(trig_ctrl_pkg::MASTER_RUN_OFS, 8'h00);
      lines(1);
      check("sync_oe_run", {15'h0000, hs_oe & vs_oe}, 16'h0001);
      wr(trig_ctrl_pkg::SYNC_DRIVE_OFS, 8'h30);
      lines(1);
      check("sync_oe_hiz", {15'h0000, hs_oe | vs_oe}, 16'h0000);
      rd(trig_ctrl_pkg::SYNC_DRIVE_OFS, 8'h30, "sync_drive");
      wr(trig_ctrl_pkg::MODE_SEL_OFS, 8'h01);
      lines(16);
      check("fast_sel_invalid", 16'(n_inv), 16'h0004);
      pa0 = n_pa;
      frame(40, 1'b0);
      check("fast_start", 16'(n_lat <= 7), 16'h0001);
      near("fast_exp", n_exp, 40 + OFS, 4);
      check("fast_pulse_a", 16'(n_pa - pa0), 16'h0000);
      check("fast_pulse_b", {15'h0000, pb}, 16'h0000);
      check("master_sync", 16'(n_hs > 8 && n_vs != 0), 16'h0001);
      $display("test fast trigger done");
      report_and_stop();
   end

   initial begin
      repeat (40000) @(posedge mclk);
      n_mismatch++;
      report_and_stop();
   end
endmodule

`default_nettype wire
